// *** anar_pkg.sv ***
// Constants shared by the auto-negotiation ability register pair
package anar_pkg;

  // ==========================================================================
  // Register map (index is the word index, byte address is four times it)
  // ==========================================================================
  localparam int unsigned ANAR_DW       = 32;
  localparam int unsigned ANAR_AW       = 8;
  localparam logic [5:0]  ADV_IDX       = 6'h04;
  localparam logic [5:0]  LP_IDX        = 6'h05;
  localparam logic [5:0]  CTL_IDX       = 6'h10;
  localparam logic [7:0]  ADV_ADDR      = {ADV_IDX, 2'h0};
  localparam logic [7:0]  LP_ADDR       = {LP_IDX, 2'h0};
  localparam logic [7:0]  CTL_ADDR      = {CTL_IDX, 2'h0};

  // ==========================================================================
  // Advertisement word fields
  // ==========================================================================
  localparam int unsigned ADV_NP_BIT    = 15;
  localparam int unsigned ADV_RSV14_BIT = 14;
  localparam int unsigned ADV_RF_BIT    = 13;
  localparam int unsigned ADV_XNP_BIT   = 12;
  localparam int unsigned ADV_ASYM_BIT  = 11;
  localparam int unsigned ADV_SYM_BIT   = 10;
  localparam int unsigned ADV_RSV9_BIT  = 9;
  localparam int unsigned ADV_FD100_BIT = 8;
  localparam int unsigned ADV_HD100_BIT = 7;
  localparam int unsigned ADV_FD10_BIT  = 6;
  localparam int unsigned ADV_HD10_BIT  = 5;
  localparam int unsigned ADV_SEL_MSB   = 4;
  localparam int unsigned ADV_SEL_LSB   = 0;
  localparam logic [15:0] ADV_WR_MASK   = 16'hBDFF;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic        ADV_NP_RST    = 1'b0;
  localparam logic        ADV_RF_RST    = 1'b0;
  localparam logic        ADV_XNP_RST   = 1'b0;
  localparam logic        ADV_FD100_RST = 1'b1;
  localparam logic        ADV_HD100_RST = 1'b1;
  localparam logic [4:0]  ADV_SEL_RST   = 5'h01;
  localparam logic [15:0] LP_RST        = 16'h0000;

  // ==========================================================================
  // Partner word and control register fields
  // ==========================================================================
  localparam int unsigned LP_ACK_BIT     = 14;
  localparam int unsigned CTL_RESTART_BIT = 0;
  localparam int unsigned CTL_RCVD_BIT   = 1;
  localparam int unsigned CTL_STRAP_LSB  = 4;
  localparam int unsigned STRAP_W        = 6;

endpackage : anar_pkg

// *** anar_sync.sv ***
// Two-flop synchroniser for static configuration pins
`timescale 1ns/1ns
module anar_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             i_ref_clk,
  input  wire logic [WIDTH-1:0] i_d,
  output logic      [WIDTH-1:0] o_q
);

  // No reset here: the straps must already be valid while reset is held
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge i_ref_clk) begin
    meta_q <= i_d;
    sync_q <= meta_q;
  end

  assign o_q = sync_q;

endmodule : anar_sync

// *** anar_regs.sv ***
// Auto-negotiation local advertisement and partner ability registers, APB slave
`timescale 1ns/1ns
module anar_regs
  import anar_pkg::*;
(
  input  wire logic               i_ref_clk,
  input  wire logic               i_resetn,
  input  wire logic               i_psel,
  input  wire logic               i_penable,
  input  wire logic               i_pwrite,
  input  wire logic [ANAR_AW-1:0] i_paddr,
  input  wire logic [ANAR_DW-1:0] i_pwdata,
  output logic      [ANAR_DW-1:0] o_prdata,
  output logic                    o_pready,
  output logic                    o_pslverr,
  input  wire logic               i_autoneg_cfg_pin,
  input  wire logic               i_speed_cfg_pin,
  input  wire logic               i_duplex_cfg_pin,
  input  wire logic               i_manual_pause_cfg_pin,
  input  wire logic               i_full_duplex_pause_cfg_pin,
  input  wire logic               i_fiber_mode_pin,
  input  wire logic [15:0]        i_rx_word,
  input  wire logic               i_rx_word_valid,
  input  wire logic               i_an_restart,
  input  wire logic               i_tx_page_req,
  output logic      [15:0]        o_tx_page,
  output logic                    o_tx_page_valid,
  output logic                    o_restart_req
);

  // ==========================================================================
  // Configuration pins
  // ==========================================================================
  logic [STRAP_W-1:0] strap_raw;
  logic [STRAP_W-1:0] strap_s;
  logic               s_autoneg;
  logic               s_speed;
  logic               s_duplex;
  logic               s_manual;
  logic               s_fd_pause;
  logic               s_fiber;

  assign strap_raw = {i_fiber_mode_pin, i_full_duplex_pause_cfg_pin,
                      i_manual_pause_cfg_pin, i_duplex_cfg_pin,
                      i_speed_cfg_pin, i_autoneg_cfg_pin};

  anar_sync #(
    .WIDTH (STRAP_W)
  ) u_strap_sync (
    .i_ref_clk (i_ref_clk),
    .i_d       (strap_raw),
    .o_q       (strap_s)
  );

  assign s_autoneg  = strap_s[0];
  assign s_speed    = strap_s[1];
  assign s_duplex   = strap_s[2];
  assign s_manual   = strap_s[3];
  assign s_fd_pause = strap_s[4];
  assign s_fiber    = strap_s[5];

  // ==========================================================================
  // Strap-derived defaults
  // ==========================================================================
  logic        dflt_sym;
  logic        dflt_asym;
  logic        dflt_fd10;
  logic        dflt_hd10;
  logic [15:0] adv_dflt;

  assign dflt_sym  = !s_fiber && !s_manual;
  assign dflt_asym = !s_fiber && !s_manual && s_fd_pause;
  assign dflt_fd10 = !s_fiber && (s_autoneg || (!s_speed && s_duplex));
  assign dflt_hd10 = !s_fiber && (s_autoneg || !s_speed);

  always_comb begin
    adv_dflt                            = 16'h0000;
    adv_dflt[ADV_NP_BIT]                = ADV_NP_RST;
    adv_dflt[ADV_RF_BIT]                = ADV_RF_RST;
    adv_dflt[ADV_XNP_BIT]               = ADV_XNP_RST;
    adv_dflt[ADV_ASYM_BIT]              = dflt_asym;
    adv_dflt[ADV_SYM_BIT]               = dflt_sym;
    adv_dflt[ADV_FD100_BIT]             = ADV_FD100_RST;
    adv_dflt[ADV_HD100_BIT]             = ADV_HD100_RST;
    adv_dflt[ADV_FD10_BIT]              = dflt_fd10;
    adv_dflt[ADV_HD10_BIT]              = dflt_hd10;
    adv_dflt[ADV_SEL_MSB:ADV_SEL_LSB]   = ADV_SEL_RST;
  end

  // ==========================================================================
  // APB decode
  // ==========================================================================
  logic setup_ph;
  logic access_ph;
  logic hit_adv;
  logic hit_lp;
  logic hit_ctl;
  logic wr_adv;
  logic wr_ctl;

  assign setup_ph  = i_psel && !i_penable;
  assign access_ph = i_psel && i_penable;
  assign hit_adv   = (i_paddr == ADV_ADDR);
  assign hit_lp    = (i_paddr == LP_ADDR);
  assign hit_ctl   = (i_paddr == CTL_ADDR);
  assign wr_adv    = access_ph && i_pwrite && hit_adv;
  assign wr_ctl    = access_ph && i_pwrite && hit_ctl;

  // Zero wait states; read data is latched in the setup cycle
  assign o_pready  = 1'b1;
  assign o_pslverr = access_ph && !(hit_adv || hit_lp || hit_ctl);

  // ==========================================================================
  // Local advertisement register
  // ==========================================================================
  logic [15:0] adv_q;

  // Loaded from the straps for as long as reset is held
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      adv_q <= adv_dflt;
    end else if (wr_adv) begin
      adv_q <= i_pwdata[15:0] & ADV_WR_MASK;
    end
  end

  // ==========================================================================
  // Partner base page register
  // ==========================================================================
  logic [15:0] lp_q;
  logic        lp_clr;

  assign lp_clr = i_an_restart || (wr_ctl && i_pwdata[CTL_RESTART_BIT]);

  // Capture wins over a restart in the same cycle; bus writes reach here only as a control restart
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      lp_q <= LP_RST;
    end else if (i_rx_word_valid) begin
      lp_q             <= i_rx_word;
      lp_q[LP_ACK_BIT] <= 1'b1;
    end else if (lp_clr) begin
      lp_q <= LP_RST;
    end
  end

  // ==========================================================================
  // Control and status
  // ==========================================================================
  logic rcvd_q;
  logic restart_q;
  logic rcvd_clr;

  assign rcvd_clr = wr_ctl && i_pwdata[CTL_RCVD_BIT];

  // Sticky page flag, write one to clear, a new page beats the clear
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      rcvd_q <= 1'b0;
    end else if (i_rx_word_valid) begin
      rcvd_q <= 1'b1;
    end else if (rcvd_clr) begin
      rcvd_q <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      restart_q <= 1'b0;
    end else begin
      restart_q <= wr_ctl && i_pwdata[CTL_RESTART_BIT];
    end
  end

  assign o_restart_req = restart_q;

  // ==========================================================================
  // Read data
  // ==========================================================================
  logic [ANAR_DW-1:0] rd_mux;
  logic [ANAR_DW-1:0] prdata_q;

  always_comb begin
    rd_mux = '0;
    if (hit_adv) begin
      rd_mux[15:0] = adv_q;
    end else if (hit_lp) begin
      rd_mux[15:0] = lp_q;
    end else if (hit_ctl) begin
      rd_mux[CTL_RCVD_BIT]                      = rcvd_q;
      rd_mux[CTL_STRAP_LSB +: STRAP_W]          = strap_s;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      prdata_q <= '0;
    end else if (setup_ph && !i_pwrite) begin
      prdata_q <= rd_mux;
    end
  end

  assign o_prdata = prdata_q;

  // ==========================================================================
  // Base page toward the link
  // ==========================================================================
  logic [15:0] tx_page_q;
  logic        tx_valid_q;

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      tx_page_q <= 16'h0000;
    end else if (i_tx_page_req) begin
      tx_page_q <= adv_q;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      tx_valid_q <= 1'b0;
    end else begin
      tx_valid_q <= i_tx_page_req;
    end
  end

  assign o_tx_page       = tx_page_q;
  assign o_tx_page_valid = tx_valid_q;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge i_ref_clk);
  endclocking

  default disable iff (!i_resetn);

  chk_rsvd_zero: assert property (
    !adv_q[ADV_RSV14_BIT] && !adv_q[ADV_RSV9_BIT]
  ) else $error("reserved advertisement bit set");

  chk_np_rf_reset: assert property (
    $rose(i_resetn) |-> !adv_q[ADV_NP_BIT] && !adv_q[ADV_RF_BIT]
  ) else $error("next page or remote fault not zero after reset");

  chk_adv_write: assert property (
    wr_adv |=> adv_q == ($past(i_pwdata[15:0]) & ADV_WR_MASK)
  ) else $error("advertisement write not stored");

  chk_pause_auto: assert property (
    $rose(i_resetn) && !$past(s_manual) && !$past(s_fiber) |->
      adv_q[ADV_SYM_BIT] && (adv_q[ADV_ASYM_BIT] == $past(s_fd_pause))
  ) else $error("pause defaults wrong without manual strap");

  chk_pause_manual: assert property (
    $rose(i_resetn) && $past(s_manual) |->
      !adv_q[ADV_SYM_BIT] && !adv_q[ADV_ASYM_BIT]
  ) else $error("pause defaults not zero with manual strap");

  chk_fiber_reset: assert property (
    $rose(i_resetn) && $past(s_fiber) |->
      adv_q[ADV_ASYM_BIT:ADV_SYM_BIT] == 2'h0
  ) else $error("fiber mode pause defaults wrong");

  chk_fiber_ten: assert property (
    $rose(i_resetn) && $past(s_fiber) |->
      adv_q[ADV_FD10_BIT:ADV_HD10_BIT] == 2'h0
  ) else $error("fiber mode 10BASE-T defaults wrong");

  // Expected values rebuilt from the straps, not from the default logic
  chk_fd10_reset: assert property (
    $rose(i_resetn) && !$past(s_fiber) |->
      adv_q[ADV_FD10_BIT] == ($past(s_autoneg) || (!$past(s_speed) && $past(s_duplex)))
  ) else $error("10BASE-T full duplex default wrong");

  chk_hd10_reset: assert property (
    $rose(i_resetn) && !$past(s_fiber) |->
      adv_q[ADV_HD10_BIT] == ($past(s_autoneg) || !$past(s_speed))
  ) else $error("10BASE-T half duplex default wrong");

  chk_fixed_reset: assert property (
    $rose(i_resetn) |->
      adv_q[ADV_SEL_MSB:ADV_SEL_LSB] == ADV_SEL_RST && adv_q[ADV_FD100_BIT] && adv_q[ADV_HD100_BIT]
  ) else $error("selector or 100BASE-X defaults wrong");

  chk_lp_capture: assert property (
    i_rx_word_valid |=> lp_q[LP_ACK_BIT] && lp_q[13:0] == $past(i_rx_word[13:0])
      && lp_q[15] == $past(i_rx_word[15])
  ) else $error("partner word not captured");

  chk_lp_readonly: assert property (
    access_ph && i_pwrite && hit_lp && !i_rx_word_valid && !lp_clr |=> $stable(lp_q)
  ) else $error("partner word changed by bus write");

  chk_tx_page: assert property (
    i_tx_page_req |=> o_tx_page_valid && o_tx_page == $past(adv_q)
  ) else $error("base page does not match advertisement");

  // A clear one cycle after the page is legal, so only it may drop the flag
  chk_rcvd_wins: assert property (
    i_rx_word_valid |=> rcvd_q ##1 (rcvd_q || $past(rcvd_clr))
  ) else $error("page flag lost");

  chk_read_data: assert property (
    setup_ph && !i_pwrite && hit_adv |=> o_prdata == {16'h0000, $past(adv_q)}
  ) else $error("read data mismatch");

  chk_lp_restart: assert property (
    lp_clr && !i_rx_word_valid |=> lp_q == LP_RST
  ) else $error("partner word not cleared by restart");

  chk_restart_pulse: assert property (
    wr_ctl && i_pwdata[CTL_RESTART_BIT] |=> o_restart_req ##1 !o_restart_req
  ) else $error("restart request not a single pulse");

  chk_lp_reset: assert property (
    $rose(i_resetn) |-> lp_q == LP_RST
  ) else $error("partner word not zero after reset");

  chk_tx_hold: assert property (
    o_tx_page_valid && !i_tx_page_req |=> $stable(o_tx_page)
  ) else $error("base page changed without request");

  cov_rx_page: cover property (i_rx_word_valid ##1 access_ph && hit_lp);
  cov_adv_write: cover property (wr_adv ##[1:20] i_tx_page_req);
  cov_restart: cover property (wr_ctl && i_pwdata[CTL_RESTART_BIT]);
  cov_unmapped: cover property (o_pslverr);

endmodule : anar_regs

// *** anar_link_partner.sv ***
// Behavioural link partner that sends base pages and asks for ours
`timescale 1ns/1ns
module anar_link_partner (
  input  wire logic        i_ref_clk,
  output logic      [15:0] o_rx_word,
  output logic             o_rx_word_valid,
  output logic             o_tx_page_req,
  input  wire logic [15:0] i_tx_page,
  input  wire logic        i_tx_page_valid
);
  initial begin
    o_rx_word       = 16'h5A5A;
    o_rx_word_valid = 1'b0;
    o_tx_page_req   = 1'b0;
  end

  // =========================================================================
  // Two words on consecutive cycles, then the word lines show junk
  // =========================================================================
  task automatic send_two(input logic [15:0] a, input logic [15:0] b);
    o_rx_word       <= a;
    o_rx_word_valid <= 1'b1;
    @(posedge i_ref_clk);
    o_rx_word       <= b;
    @(posedge i_ref_clk);
    o_rx_word_valid <= 1'b0;
    // Inverted value so a stale word can never look valid by accident
    o_rx_word       <= ~b;
    @(posedge i_ref_clk);
  endtask : send_two

  // =========================================================================
  // Ask for the local base page and wait a bounded time for it
  // =========================================================================
  task automatic fetch_page(output logic [15:0] p);
    int n;
    o_tx_page_req <= 1'b1;
    @(posedge i_ref_clk);
    o_tx_page_req <= 1'b0;
    n = 0;
    do begin
      @(posedge i_ref_clk);
      n++;
    end while (i_tx_page_valid !== 1'b1 && n < 20);
    p = (i_tx_page_valid === 1'b1) ? i_tx_page : 16'hDEAD;
  endtask : fetch_page
endmodule : anar_link_partner

// *** test_autoneg_ability_registers.sv ***
// Self-checking bench for the advertisement and partner ability registers
`timescale 1ns/1ns
module test_autoneg_ability_registers;
  import anar_pkg::*;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, an_restart = 1'b0;
  logic [5:0]  straps = 6'h00;
  logic [15:0] rx_word, tx_page;
  logic        rx_valid, page_req, page_valid, restart_req;
  int          miscompares = 0, n_compared = 0, cycles = 0, n_restart = 0;
  logic [31:0] rd;
  logic        err;
  logic [15:0] pg;

  always #5 clk = ~clk;

  anar_regs uut (.i_ref_clk(clk), .i_resetn(resetn), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_autoneg_cfg_pin(straps[0]), .i_speed_cfg_pin(straps[1]), .i_duplex_cfg_pin(straps[2]),
    .i_manual_pause_cfg_pin(straps[3]), .i_full_duplex_pause_cfg_pin(straps[4]), .i_fiber_mode_pin(straps[5]),
    .i_rx_word(rx_word), .i_rx_word_valid(rx_valid), .i_an_restart(an_restart), .i_tx_page_req(page_req),
    .o_tx_page(tx_page), .o_tx_page_valid(page_valid), .o_restart_req(restart_req));

  anar_link_partner partner (.i_ref_clk(clk), .o_rx_word(rx_word), .o_rx_word_valid(rx_valid),
    .o_tx_page_req(page_req), .i_tx_page(tx_page), .i_tx_page_valid(page_valid));

  // =========================================================================
  // Shared helpers
  // =========================================================================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; entered just after a rising edge, leaves an idle cycle
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // No local limit: only the bench timeout ends a hung wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic do_reset(input logic [5:0] s);
    straps <= s;
    resetn <= 1'b0;
    // Straps pass a two-flop synchroniser, so hold reset past it
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
  endtask : do_reset

  // Straps: 0 autoneg, 1 speed, 2 duplex, 3 manual pause, 4 fd pause, 5 fiber
  function automatic logic [31:0] adv_default(input logic [5:0] s);
    logic [15:0] v;
    v = 16'h0181;
    if (!s[5]) begin
      v[10] = !s[3];
      v[11] = !s[3] & s[4];
      v[6]  = s[0] | (!s[1] & s[2]);
      v[5]  = s[0] | !s[1];
    end
    return {16'h0000, v};
  endfunction : adv_default

  // =========================================================================
  // Scenarios
  // =========================================================================
  task automatic t_defaults;
    for (int i = 0; i < 64; i++) begin
      do_reset(i[5:0]);
      apb(1'b0, ADV_ADDR, 32'h0);
      chk(rd, adv_default(i[5:0]));
      apb(1'b0, LP_ADDR, 32'h0);
      chk(rd, 32'h0);
    end
    $display("t_defaults done");
  endtask : t_defaults

  task automatic t_write;
    do_reset(6'h00);
    apb(1'b1, ADV_ADDR, 32'hFFFF_EFFF);
    apb(1'b0, ADV_ADDR, 32'h0);
    chk(rd, 32'h0000_ADFF);
    partner.fetch_page(pg);
    chk({16'h0, pg}, 32'h0000_ADFF);
    apb(1'b1, ADV_ADDR, 32'h0000_2C1E);
    apb(1'b0, ADV_ADDR, 32'h0);
    chk(rd, 32'h0000_2C1E);
    apb(1'b1, ADV_ADDR, 32'h0000_0000);
    apb(1'b0, ADV_ADDR, 32'h0);
    chk(rd, 32'h0);
    partner.fetch_page(pg);
    chk({16'h0, pg}, 32'h0);
    $display("t_write done");
  endtask : t_write

  task automatic t_partner;
    do_reset(6'h01);
    partner.send_two(16'h0400, 16'hBBE1);
    apb(1'b0, LP_ADDR, 32'h0);
    chk(rd, 32'h0000_FBE1);
    apb(1'b1, LP_ADDR, 32'h0);
    chk({31'h0, err}, 32'h0);
    apb(1'b0, LP_ADDR, 32'h0);
    chk(rd, 32'h0000_FBE1);
    an_restart <= 1'b1;
    @(posedge clk);
    an_restart <= 1'b0;
    @(posedge clk);
    apb(1'b0, LP_ADDR, 32'h0);
    chk(rd, 32'h0);
    partner.send_two(16'h0001, 16'h0401);
    apb(1'b0, LP_ADDR, 32'h0);
    chk(rd, 32'h0000_4401);
    $display("t_partner done");
  endtask : t_partner

  // Control word: sampled straps, sticky page flag, restart pulse
  task automatic t_control;
    do_reset(6'h2A);
    partner.send_two(16'h0021, 16'h0421);
    apb(1'b0, CTL_ADDR, 32'h0);
    chk(rd, 32'h0000_02A2);
    chk({31'h0, pready}, 32'h1);
    apb(1'b1, CTL_ADDR, 32'h0000_0002);
    apb(1'b0, CTL_ADDR, 32'h0);
    chk(rd, 32'h0000_02A0);
    apb(1'b1, CTL_ADDR, 32'h0000_0001);
    chk({31'h0, err}, 32'h0);
    apb(1'b0, LP_ADDR, 32'h0);
    chk(rd, 32'h0);
    chk(n_restart, 32'h1);
    $display("t_control done");
  endtask : t_control

  task automatic t_unmapped;
    apb(1'b1, 8'h08, 32'h0000_FFFF);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 8'h08, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    $display("t_unmapped done");
  endtask : t_unmapped

  // =========================================================================
  // Run control
  // =========================================================================
  task automatic tally_and_finish;
    $display("Compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  always @(posedge clk) begin
    cycles++;
    if (restart_req === 1'b1) begin
      n_restart++;
    end
    if (cycles == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_defaults();
    t_write();
    t_partner();
    t_control();
    t_unmapped();
    tally_and_finish();
  end
endmodule : test_autoneg_ability_registers
